// >>> hw/checksum_regs.svh
// Register offsets, field positions and reset values of the checksum engine
`ifndef CHECKSUM_REGS_SVH
`define CHECKSUM_REGS_SVH

`define CSUM_CTRL_OFS     5'h00
`define CSUM_DATA_OFS     5'h04
`define CSUM_SEED_OFS     5'h08
`define CSUM_RESULT_OFS   5'h0C
`define CSUM_STATUS_OFS   5'h10

`define CSUM_CTRL_POLY_LSB   0
`define CSUM_CTRL_IN_REV_BIT 2
`define CSUM_CTRL_SWAP_BIT   3
`define CSUM_CTRL_OUT_LSB    4
`define CSUM_CTRL_HOLD_BIT   6
`define CSUM_CTRL_INIT_BIT   7

`define CSUM_STAT_BUSY_BIT   0
`define CSUM_STAT_FULL_BIT   1
`define CSUM_STAT_CNT_LSB    8

`define CSUM_CTRL_RESET   32'h0000_0000
`define CSUM_SEED_RESET   32'hFFFF_FFFF
`define CSUM_CRC_RESET    32'hFFFF_FFFF

`define CSUM_POLY_32      32'h04C1_1DB7
`define CSUM_POLY_16A     32'h0000_1021
`define CSUM_POLY_16B     32'h0000_3D65
`define CSUM_POLY_16C     32'h0000_8005

`define CSUM_WORD_BITS    32
`define CSUM_BYTE_BITS    8

`endif

// >>> hw/checksum_pkg.sv
// Types shared by the checksum engine modules
package checksum_pkg;

  typedef enum logic [1:0] {
    POLY_32         = 2'h0,
    POLY_16_FIRST   = 2'h1,
    POLY_16_SECOND  = 2'h2,
    POLY_16_THIRD   = 2'h3
  } poly_sel_e;

  typedef enum logic [1:0] {
    OUT_PLAIN = 2'h0,
    OUT_WORD  = 2'h1,
    OUT_HALF  = 2'h2,
    OUT_SPARE = 2'h3
  } out_mode_e;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_e;

  typedef struct packed {
    bus_state_e  bus;
    logic        wait_req;
    logic [31:0] rdata;
    poly_sel_e   poly;
    logic        in_rev;
    logic        swap;
    out_mode_e   out_mode;
    logic        hold;
    logic [31:0] seed;
    logic [31:0] crc;
  } eng_state_s;

endpackage

// >>> hw/stream_if.sv
// Valid/ready word stream between the engine and its input FIFO
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(
  parameter int WIDTH = 33
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> hw/word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic srst,
  stream_if.snk     push,
  stream_if.src     pop,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers wrap by overflow, so depth must be a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("word_fifo: DEPTH must be a power of two and at least 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("word_fifo: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_s;

  fifo_state_s s_r;
  fifo_state_s s_nxt;
  logic        do_push;
  logic        do_pop;

  assign push.ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign pop.valid  = (s_r.cnt != '0);
  assign pop.data   = s_r.mem[s_r.rd];
  assign level      = s_r.cnt;
  assign do_push    = push.valid & push.ready;
  assign do_pop     = pop.valid & pop.ready;

  always_comb begin
    s_nxt = s_r;
    if (do_push) begin
      s_nxt.mem[s_r.wr] = push.data;
      s_nxt.wr          = s_r.wr + AW'(1);
    end
    if (do_pop) begin
      s_nxt.rd = s_r.rd + AW'(1);
    end
    case ({do_push, do_pop})
      2'b10:   s_nxt.cnt = s_r.cnt + (AW+1)'(1);
      2'b01:   s_nxt.cnt = s_r.cnt - (AW+1)'(1);
      default: s_nxt.cnt = s_r.cnt;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> hw/polynomial_checksum_engine.sv
// Checksum engine: Avalon-MM slave, input FIFO and single-cycle CRC datapath
//
// Operation
// [R1] One 32-bit polynomial 0x04C11DB7 offered
// [R2] Three 16-bit polynomials; four choices total
// [R3] Optional bit reversal inside each input byte
// [R4] Optional byte reordering of each input word
// [R5] Optional result reversal, full word or half-word
// [R6] One control write configures and seeds accumulator
// [R7] Whole 32- or 8-bit block per clock
// [R8] One 32-bit word per clock sustained; the bus slave accepts one data write every two clocks
// [R9] Fed by software-paced DMA writes, no request
// [R10] 16-bit mode: result low half, upper zero
// [R11] Master seeds before writing new computation data
`include "checksum_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module polynomial_checksum_engine #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest
);
  localparam int FW = 33;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_bad_depth
    $error("polynomial_checksum_engine: FIFO_DEPTH out of range 2..128");
  end

  checksum_pkg::eng_state_s s_r;
  checksum_pkg::eng_state_s s_nxt;

  stream_if #(.WIDTH(FW)) push_if ();
  stream_if #(.WIDTH(FW)) pop_if ();

  logic [LW-1:0] fifo_level;
  logic [31:0]   lane_mask;
  logic [31:0]   ctrl_view;
  logic [31:0]   ctrl_new;
  logic [31:0]   swapped;
  logic [31:0]   in_word;
  logic [31:0]   rev_bytes;
  logic [31:0]   rev_full;
  logic [31:0]   rev_half;
  logic [7:0]    low_rev;
  logic [31:0]   result_view;
  logic [31:0]   status_view;
  logic [31:0]   fold_data;
  logic [31:0]   fold_poly;
  logic [31:0]   crc_folded;
  logic          wide;
  logic          blk_byte;
  logic          fifo_empty;
  logic          req;
  logic          sel_ctrl;
  logic          sel_data;
  logic          sel_seed;
  logic          sel_result;
  logic          sel_status;
  logic          can_answer;

  word_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .srst  (srst),
    .push  (push_if.snk),
    .pop   (pop_if.src),
    .level (fifo_level)
  );

  // Unrolled bitwise fold, MSB first, of the low n bits of d
  function automatic logic [31:0] crc_fold(
    input logic [31:0] c,
    input logic [31:0] d,
    input int          n,
    input logic [31:0] p,
    input logic        w
  );
    logic [31:0] r;
    logic        fb;
    r  = c;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (i < n) begin
        fb = (w ? r[31] : r[15]) ^ d[i];
        r  = {r[30:0], 1'b0};
        if (fb) begin
          r = r ^ p;
        end
        if (!w) begin
          r[31:16] = '0;
        end
      end
    end
    return r;
  endfunction

  // Byte lanes, input byte mirror and output mirrors share one per-bit loop
  for (genvar b = 0; b < 32; b++) begin : g_bit
    assign lane_mask[b] = byteenable[b / 8];
    assign rev_bytes[b] = swapped[(b / 8) * 8 + 7 - (b % 8)];
    assign rev_full[b]  = s_r.crc[31 - b];
    assign rev_half[b]  = s_r.crc[(b / 16) * 16 + 15 - (b % 16)];
    // Byte block mirror taken before the reorder, lane 0 only
    if (b < 8) begin : g_low
      assign low_rev[b] = pop_if.data[7 - b];
    end
  end

  assign wide       = (s_r.poly == checksum_pkg::POLY_32);
  assign fifo_empty = !pop_if.valid;
  assign blk_byte   = pop_if.data[32];

  // [R4] byte reorder
  assign swapped = s_r.swap ? {pop_if.data[7:0], pop_if.data[15:8],
                               pop_if.data[23:16], pop_if.data[31:24]}
                            : pop_if.data[31:0];

  // [R3] per-byte mirror
  assign in_word = s_r.in_rev ? rev_bytes : swapped;

  // A byte block uses only its own lane; reorder cannot move it
  assign fold_data = blk_byte ? {24'h00_0000, (s_r.in_rev ? low_rev
                                                          : pop_if.data[7:0])}
                              : in_word;

  // [R1] [R2] polynomial choice
  always_comb begin
    case (s_r.poly)
      checksum_pkg::POLY_32:        fold_poly = `CSUM_POLY_32;
      checksum_pkg::POLY_16_FIRST:  fold_poly = `CSUM_POLY_16A;
      checksum_pkg::POLY_16_SECOND: fold_poly = `CSUM_POLY_16B;
      checksum_pkg::POLY_16_THIRD:  fold_poly = `CSUM_POLY_16C;
      default:                      fold_poly = `CSUM_POLY_32;
    endcase
  end

  // [R7] single-cycle fold
  assign crc_folded = crc_fold(s_r.crc, fold_data,
                               blk_byte ? `CSUM_BYTE_BITS : `CSUM_WORD_BITS,
                               fold_poly, wide);

  // [R5] [R10] result view
  always_comb begin
    case (s_r.out_mode)
      checksum_pkg::OUT_WORD:
        result_view = wide ? rev_full : {16'h0000, rev_half[15:0]};
      checksum_pkg::OUT_HALF:
        result_view = wide ? rev_half : {16'h0000, rev_half[15:0]};
      default:
        result_view = wide ? s_r.crc : {16'h0000, s_r.crc[15:0]};
    endcase
  end

  always_comb begin
    ctrl_view = '0;
    ctrl_view[`CSUM_CTRL_POLY_LSB +: 2] = s_r.poly;
    ctrl_view[`CSUM_CTRL_IN_REV_BIT]    = s_r.in_rev;
    ctrl_view[`CSUM_CTRL_SWAP_BIT]      = s_r.swap;
    ctrl_view[`CSUM_CTRL_OUT_LSB +: 2]  = s_r.out_mode;
    ctrl_view[`CSUM_CTRL_HOLD_BIT]      = s_r.hold;
  end

  assign ctrl_new = (ctrl_view & ~lane_mask) | (writedata & lane_mask);

  always_comb begin
    status_view = '0;
    status_view[`CSUM_STAT_BUSY_BIT]       = !fifo_empty;
    status_view[`CSUM_STAT_FULL_BIT]       = !push_if.ready;
    status_view[`CSUM_STAT_CNT_LSB +: LW]  = fifo_level;
  end

  assign req        = read | write;
  assign sel_ctrl   = (address == `CSUM_CTRL_OFS);
  assign sel_data   = (address == `CSUM_DATA_OFS);
  assign sel_seed   = (address == `CSUM_SEED_OFS);
  assign sel_result = (address == `CSUM_RESULT_OFS);
  assign sel_status = (address == `CSUM_STATUS_OFS);

  // Data writes stall on a full FIFO; result reads wait for the drain unless hold is set,
  // so without hold the value covers every word already accepted.
  always_comb begin
    can_answer = 1'b1;
    if (write && sel_data) begin
      can_answer = push_if.ready;
    end else if (read && sel_result) begin
      can_answer = fifo_empty || s_r.hold;
    end
  end

  // [R9] accepted data words go straight to the FIFO
  assign push_if.valid = (s_r.bus == checksum_pkg::BUS_IDLE) && write && sel_data;
  assign push_if.data  = {(byteenable == 4'h1), writedata};

  // [R8] engine drains every clock unless held
  assign pop_if.ready = !s_r.hold;

  always_comb begin
    s_nxt = s_r;
    if (pop_if.valid && !s_r.hold) begin
      s_nxt.crc = crc_folded;
    end
    case (s_r.bus)
      checksum_pkg::BUS_IDLE: begin
        if (req && can_answer) begin
          s_nxt.bus      = checksum_pkg::BUS_DONE;
          s_nxt.wait_req = 1'b0;
          if (read) begin
            if (sel_ctrl) begin
              s_nxt.rdata = ctrl_view;
            end else if (sel_seed) begin
              s_nxt.rdata = s_r.seed;
            end else if (sel_result) begin
              s_nxt.rdata = result_view;
            end else if (sel_status) begin
              s_nxt.rdata = status_view;
            end else begin
              s_nxt.rdata = '0;
            end
          end else if (sel_ctrl) begin
            // [R6] configure and seed at once
            s_nxt.poly     = checksum_pkg::poly_sel_e'(ctrl_new[`CSUM_CTRL_POLY_LSB +: 2]);
            s_nxt.in_rev   = ctrl_new[`CSUM_CTRL_IN_REV_BIT];
            s_nxt.swap     = ctrl_new[`CSUM_CTRL_SWAP_BIT];
            s_nxt.out_mode = checksum_pkg::out_mode_e'(ctrl_new[`CSUM_CTRL_OUT_LSB +: 2]);
            s_nxt.hold     = ctrl_new[`CSUM_CTRL_HOLD_BIT];
            // [R11] seed overrides any word folded this cycle
            if (byteenable[0] && writedata[`CSUM_CTRL_INIT_BIT]) begin
              s_nxt.crc = (ctrl_new[`CSUM_CTRL_POLY_LSB +: 2] == 2'h0)
                          ? s_r.seed : {16'h0000, s_r.seed[15:0]};
            end
          end else if (sel_seed) begin
            s_nxt.seed = (s_r.seed & ~lane_mask) | (writedata & lane_mask);
          end
        end
      end
      checksum_pkg::BUS_DONE: begin
        s_nxt.bus      = checksum_pkg::BUS_IDLE;
        s_nxt.wait_req = 1'b1;
      end
      default: begin
        s_nxt.bus      = checksum_pkg::BUS_IDLE;
        s_nxt.wait_req = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r.bus      <= checksum_pkg::BUS_IDLE;
      s_r.wait_req <= 1'b1;
      s_r.rdata    <= '0;
      s_r.poly     <= checksum_pkg::POLY_32;
      s_r.in_rev   <= 1'b0;
      s_r.swap     <= 1'b0;
      s_r.out_mode <= checksum_pkg::OUT_PLAIN;
      s_r.hold     <= 1'b0;
      s_r.seed     <= `CSUM_SEED_RESET;
      s_r.crc      <= `CSUM_CRC_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign readdata    = s_r.rdata;
  assign waitrequest = s_r.wait_req;
endmodule
`default_nettype wire

// >>> testbench/polynomial_checksum_engine_chk.sv
// Port-level assertions for the checksum engine
`include "checksum_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module polynomial_checksum_engine_chk #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  logic [6:0] ctrl_r;
  logic       rd_ans;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  assign rd_ans = read && !waitrequest;
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= 7'h00;
    end else if (write && !waitrequest && address == `CSUM_CTRL_OFS && byteenable[0]) begin
      ctrl_r <= writedata[6:0];
    end
  end
  a_answer_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  a_answer_caused: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without request");
  a_quick_answer: assert property ($rose(read || write) && address != `CSUM_DATA_OFS
    && address != `CSUM_RESULT_OFS |=> !waitrequest)
    else $error("register access not answered next cycle");
  a_data_flows: assert property ($rose(write) && address == `CSUM_DATA_OFS && !ctrl_r[6]
    |-> ##[1:8] !waitrequest)
    else $error("data word stalled while draining");
  a_read_holds: assert property ($changed(readdata) |-> rd_ans)
    else $error("read data moved outside a read answer");
  a_data_wo: assert property (rd_ans && address == `CSUM_DATA_OFS |-> readdata == 32'h0000_0000)
    else $error("data port read not zero");
  a_ctrl_back: assert property (rd_ans && address == `CSUM_CTRL_OFS
    |-> readdata == {25'h0, ctrl_r})
    else $error("control readback wrong");
  a_upper_zero: assert property (rd_ans && address == `CSUM_RESULT_OFS && ctrl_r[1:0] != 2'h0
    |-> readdata[31:16] == 16'h0000)
    else $error("16-bit result upper half not zero");
  a_status_full: assert property (rd_ans && address == `CSUM_STATUS_OFS
    |-> readdata[1] == (readdata[10:8] == FIFO_DEPTH))
    else $error("full flag disagrees with level");
endmodule
bind polynomial_checksum_engine polynomial_checksum_engine_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest));
`default_nettype wire

// >>> testbench/avalon_master.sv
// Bus master model standing for the core or software-paced DMA
`timescale 1ns/10ps
`default_nettype none
module avalon_master (
  input  wire logic        clk,
  output logic      [4:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
  end
  task automatic xfer(input bit wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q, output bit ok);
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= wr ? d : ~d;
    byteenable <= be;
    ok = 0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) begin
        ok = 1;
        q = readdata;
      end
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/polynomial_checksum_engine_test.sv
// Self-checking bench for the checksum engine
`include "checksum_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module polynomial_checksum_engine_test;
  logic        clk;
  logic        srst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [31:0] q;
  logic [31:0] acc;
  logic [31:0] w;
  logic [31:0] seed;
  logic [1:0]  p;
  logic [1:0]  om;
  bit          rv;
  bit          sw;
  int          n_errors = 0;
  int          samples_checked = 0;
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  polynomial_checksum_engine #(.FIFO_DEPTH(4)) DUT (
    .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));
  avalon_master bus (
    .clk(clk), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
  task automatic complete_run;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic go(bit wr, logic [4:0] a, logic [31:0] d, logic [3:0] be = 4'hF);
    bit ok;
    bus.xfer(wr, a, d, be, q, ok);
    if (!ok) begin
      n_errors++;
      $display("unexpected at %0t: no answer", $time);
      complete_run();
    end
  endtask
  task automatic chk(logic [31:0] exp);
    samples_checked++;
    if (q !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, q, exp);
    end
  endtask
  // MSB-first non-reflected fold of n bits
  function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] d, int n, logic [1:0] ps);
    logic [31:0] poly;
    logic        fb;
    int          wd;
    wd = ps == 2'h0 ? 32 : 16;
    poly = ps == 2'h0 ? 32'h04C1_1DB7 : ps == 2'h1 ? 32'h0000_1021 :
           ps == 2'h2 ? 32'h0000_3D65 : 32'h0000_8005;
    for (int i = n - 1; i >= 0; i--) begin
      fb = c[wd-1] ^ d[i];
      c = c << 1;
      if (fb) c = c ^ poly;
    end
    if (wd == 16) c[31:16] = 16'h0000;
    return c;
  endfunction
  function automatic logic [31:0] prep(logic [31:0] d, bit r, bit s);
    logic [31:0] a;
    logic [31:0] b;
    for (int i = 0; i < 32; i++) a[i] = r ? d[i^7] : d[i];
    for (int i = 0; i < 32; i++) b[i] = s ? a[i^24] : a[i];
    return b;
  endfunction
  function automatic logic [31:0] outx(logic [31:0] c, logic [1:0] ps, logic [1:0] m);
    logic [31:0] o;
    int          wd;
    wd = ps == 2'h0 ? 32 : 16;
    o = 32'h0000_0000;
    for (int i = 0; i < wd; i++) o[i] = (m == 2'h0) ? c[i] : c[wd-1-i];
    return o;
  endfunction
  initial begin
    srst = 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    go(0, `CSUM_CTRL_OFS, 0); chk(32'h0000_0000);
    go(0, `CSUM_SEED_OFS, 0); chk(32'hFFFF_FFFF);
    go(0, `CSUM_RESULT_OFS, 0); chk(32'hFFFF_FFFF);
    go(1, 5'h14, 32'hDEAD_BEEF);
    go(0, 5'h14, 0); chk(32'h0000_0000);
    for (int k = 0; k < 12; k++) begin
      p = 2'(k % 4);
      rv = (k / 4) == 1;
      sw = (k / 4) == 2;
      om = (p == 2'h0 && sw) ? 2'h1 : 2'(k / 4);
      seed = 32'hA5C3_0F00 ^ 32'(k);
      go(1, `CSUM_SEED_OFS, seed);
      go(1, `CSUM_CTRL_OFS, {24'h0, 2'b10, om, sw, rv, p});
      acc = p == 2'h0 ? seed : {16'h0000, seed[15:0]};
      for (int j = 0; j < 3; j++) begin
        w = 32'h0102_0304 * 32'(j + k + 1);
        go(1, `CSUM_DATA_OFS, w);
        acc = fold(acc, prep(w, rv, sw), 32, p);
      end
      go(1, `CSUM_RESULT_OFS, 32'h0);
      go(0, `CSUM_RESULT_OFS, 0); chk(outx(acc, p, om));
    end
    go(1, `CSUM_CTRL_OFS, 32'h0000_00C0);
    acc = seed;
    for (int j = 0; j < 4; j++) begin
      w = 32'h9E37_79B9 * 32'(j + 1);
      go(1, `CSUM_DATA_OFS, w, j == 3 ? 4'h1 : 4'hF);
      acc = j == 3 ? fold(acc, {24'h0, w[7:0]}, 8, 2'h0) : fold(acc, w, 32, 2'h0);
    end
    go(0, `CSUM_STATUS_OFS, 0); chk(32'h0000_0403);
    go(1, `CSUM_CTRL_OFS, 32'h0000_0000);
    go(0, `CSUM_RESULT_OFS, 0); chk(acc);
    go(0, `CSUM_STATUS_OFS, 0); chk(32'h0000_0000);
    complete_run();
  end
endmodule
`default_nettype wire
